// file: core/acc_pkg.sv
package acc_pkg;
    // ==========================================================
    // widths
    localparam int DATA_W = 24;
    localparam int CNT_W = 17;
    localparam int BIT_W = 10;
    localparam int HOLD_W = 8;
    // ==========================================================
    // chain figures
    localparam int MAX_CHAIN = 8;
    localparam int MAX_CHANNELS = 32;
    localparam logic [BIT_W-1:0] RATE_WR_BITS = 10'h010;
    localparam logic [BIT_W-1:0] RATE_RD_BITS = 10'h010;
    // ==========================================================
    // timing and reset values
    localparam int CLK_HZ = 50_000_000;
    localparam logic [HOLD_W-1:0] READY_LOW_CYC = 8'h08;
    localparam logic [CNT_W-1:0] CNT_ZERO = 17'h00000;
    localparam logic [CNT_W-1:0] CNT_MAX = 17'h1ffff;
    localparam logic [1:0] SYNC_RST = 2'h3;
    // ==========================================================
    // bus token states, gray along idle-wait-own-pass
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_WAIT = 2'b01,
        ACC_OWN = 2'b11,
        ACC_PASS = 2'b10
    } acc_bus_st_t;

    typedef struct packed {
        logic [1:0] tok_s;
        logic [1:0] cs_s;
        logic [1:0] sync_s;
        logic sync_d;
        logic [1:0] rdy_in_s;
        acc_bus_st_t bus_st;
        logic [BIT_W-1:0] bit_cnt;
        logic [BIT_W-1:0] bit_goal;
        logic rate_wr;
        logic token_out;
        logic ovr_oe;
        logic flt_oe;
        logic [CNT_W-1:0] period_cnt;
        logic [CNT_W-1:0] since_cnt;
        logic [CNT_W-1:0] stored;
        logic pend;
        logic [CNT_W-1:0] pause_cnt;
        logic tick;
        logic rdy_pending;
        logic rdy_out_n;
        logic [HOLD_W-1:0] rdy_hold;
        logic [1:0][DATA_W-1:0] buf_mem;
        logic [1:0] buf_cnt;
        logic wr_ptr;
        logic rd_ptr;
    } acc_state_t;
endpackage : acc_pkg

// file: core/acc_cascade.sv
// Contract
// - up to eight devices share one bus
// - token-in fall takes bus, pass token after
// - rate-register write: no hand-over, all load
// - rate-register read: sixteen bits per device
// - overrange line open-drain, low while active
// - fault line open-drain, low while active
// - ready low only when chain-in low, done
// - sync never aborts running conversion
// - sync measures cycles since ready fall
// - pause whole converter for stored count
// - event ending current conversion keeps period
// - post-pause event delayed, then regular period
// - sync ignored during power-on reset
// - sync with ready fall gives zero pause
`timescale 1ns/1ns
`default_nettype none
module acc_cascade (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic chain_token_in,
    output logic chain_token_out,
    input wire logic cmd_start,
    input wire logic cmd_rate_write,
    input wire logic cmd_rate_read,
    input wire logic [acc_pkg::BIT_W-1:0] cmd_bits,
    input wire logic bit_strobe,
    output logic bus_owner,
    input wire logic overrange_active,
    input wire logic fault_active,
    output logic overrange_line_n_o,
    output logic overrange_line_n_oe,
    output logic fault_line_n_o,
    output logic fault_line_n_oe,
    input wire logic sync_n,
    input wire logic ready_chain_in_n,
    output logic ready_chain_out_n,
    input wire logic [acc_pkg::CNT_W-1:0] period_cycles,
    output logic conv_tick,
    output logic converter_run,
    input wire logic conv_valid,
    input wire logic [acc_pkg::DATA_W-1:0] conv_data,
    output logic conv_ready,
    output logic out_valid,
    output logic [acc_pkg::DATA_W-1:0] out_data,
    input wire logic out_ready
);
    acc_pkg::acc_state_t st_ff;
    acc_pkg::acc_state_t nxt_st;
    logic push;
    logic pop;
    logic sync_fall;
    logic rdy_fall;
    logic cs_high;
    logic [acc_pkg::CNT_W-1:0] period_last;

    // ==========================================================
    // next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tok_s = {st_ff.tok_s[0], chain_token_in};
        nxt_st.cs_s = {st_ff.cs_s[0], cs_n};
        nxt_st.sync_s = {st_ff.sync_s[0], sync_n};
        nxt_st.sync_d = st_ff.sync_s[1];
        nxt_st.rdy_in_s = {st_ff.rdy_in_s[0], ready_chain_in_n};
        cs_high = st_ff.cs_s[1];
        // flops are held in reset, so no edge is seen before release
        sync_fall = st_ff.sync_d & ~st_ff.sync_s[1];
        push = conv_valid && (st_ff.buf_cnt != 2'h2);
        pop = (st_ff.buf_cnt != 2'h0) && out_ready;
        period_last = (period_cycles == acc_pkg::CNT_ZERO) ? acc_pkg::CNT_ZERO :
            period_cycles - 17'h00001;

        // bus token hand-over, every command reaches every device
        case (st_ff.bus_st)
            acc_pkg::ACC_IDLE: begin
                if (cmd_start && !cs_high) begin
                    nxt_st.bit_cnt = '0;
                    nxt_st.rate_wr = cmd_rate_write;
                    if (cmd_rate_write) begin
                        nxt_st.bit_goal = acc_pkg::RATE_WR_BITS;
                        nxt_st.bus_st = acc_pkg::ACC_OWN;
                    end else begin
                        nxt_st.bit_goal = cmd_rate_read ? acc_pkg::RATE_RD_BITS : cmd_bits;
                        nxt_st.bus_st = acc_pkg::ACC_WAIT;
                    end
                end
            end
            acc_pkg::ACC_WAIT: begin
                // token already low at the head of the chain counts as its edge
                if (!st_ff.tok_s[1]) begin
                    nxt_st.bus_st = acc_pkg::ACC_OWN;
                end
            end
            acc_pkg::ACC_OWN: begin
                if (bit_strobe) begin
                    nxt_st.bit_cnt = st_ff.bit_cnt + 10'h001;
                    if (st_ff.bit_cnt + 10'h001 >= st_ff.bit_goal) begin
                        if (st_ff.rate_wr) begin
                            nxt_st.bus_st = acc_pkg::ACC_IDLE;
                        end else begin
                            nxt_st.bus_st = acc_pkg::ACC_PASS;
                            nxt_st.token_out = 1'b0;
                        end
                    end
                end
            end
            acc_pkg::ACC_PASS: begin
                nxt_st.token_out = 1'b0;
            end
            default: begin
                nxt_st.bus_st = acc_pkg::ACC_IDLE;
            end
        endcase
        if (cs_high) begin
            nxt_st.bus_st = acc_pkg::ACC_IDLE;
            nxt_st.token_out = 1'b1;
        end

        // open-drain summary lines
        nxt_st.ovr_oe = overrange_active;
        nxt_st.flt_oe = fault_active;

        // two-entry result buffer
        if (push) begin
            nxt_st.buf_mem[st_ff.wr_ptr] = conv_data;
            nxt_st.wr_ptr = ~st_ff.wr_ptr;
        end
        if (pop) begin
            nxt_st.rd_ptr = ~st_ff.rd_ptr;
        end
        nxt_st.buf_cnt = st_ff.buf_cnt + {1'b0, push} - {1'b0, pop};

        // ready chain: own result plus upstream ready
        if (push) begin
            nxt_st.rdy_pending = 1'b1;
        end
        if (!st_ff.rdy_out_n) begin
            if (st_ff.rdy_hold != '0) begin
                nxt_st.rdy_hold = st_ff.rdy_hold - 8'h01;
            end else begin
                nxt_st.rdy_out_n = 1'b1;
            end
        end else if (st_ff.rdy_pending && !st_ff.rdy_in_s[1]) begin
            nxt_st.rdy_out_n = 1'b0;
            nxt_st.rdy_pending = push;
            nxt_st.rdy_hold = acc_pkg::READY_LOW_CYC - 8'h01;
        end
        rdy_fall = st_ff.rdy_out_n && !nxt_st.rdy_out_n;

        // conversion timing; sync never resets the running period
        nxt_st.tick = 1'b0;
        if (st_ff.pause_cnt != acc_pkg::CNT_ZERO) begin
            nxt_st.pause_cnt = st_ff.pause_cnt - 17'h00001;
        end else if (st_ff.period_cnt >= period_last) begin
            nxt_st.period_cnt = acc_pkg::CNT_ZERO;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.period_cnt = st_ff.period_cnt + 17'h00001;
        end
        if (st_ff.since_cnt != acc_pkg::CNT_MAX) begin
            nxt_st.since_cnt = st_ff.since_cnt + 17'h00001;
        end
        if (rdy_fall) begin
            nxt_st.since_cnt = acc_pkg::CNT_ZERO;
            if (st_ff.pend) begin
                nxt_st.pause_cnt = st_ff.stored;
                nxt_st.pend = 1'b0;
            end
        end
        if (sync_fall) begin
            // a later edge overwrites a pause not yet applied
            nxt_st.stored = rdy_fall ? acc_pkg::CNT_ZERO : st_ff.since_cnt;
            nxt_st.pend = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
            st_ff.tok_s <= acc_pkg::SYNC_RST;
            st_ff.cs_s <= acc_pkg::SYNC_RST;
            st_ff.sync_s <= acc_pkg::SYNC_RST;
            st_ff.sync_d <= 1'b1;
            st_ff.rdy_in_s <= acc_pkg::SYNC_RST;
            st_ff.bus_st <= acc_pkg::ACC_IDLE;
            st_ff.token_out <= 1'b1;
            st_ff.rdy_out_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // outputs
    assign chain_token_out = st_ff.token_out;
    assign bus_owner = (st_ff.bus_st == acc_pkg::ACC_OWN);
    assign overrange_line_n_o = 1'b0;
    assign overrange_line_n_oe = st_ff.ovr_oe;
    assign fault_line_n_o = 1'b0;
    assign fault_line_n_oe = st_ff.flt_oe;
    assign ready_chain_out_n = st_ff.rdy_out_n;
    assign conv_tick = st_ff.tick;
    assign converter_run = (st_ff.pause_cnt == acc_pkg::CNT_ZERO);
    assign conv_ready = (st_ff.buf_cnt != 2'h2);
    assign out_valid = (st_ff.buf_cnt != 2'h0);
    assign out_data = st_ff.buf_mem[st_ff.rd_ptr];

    // ==========================================================
    // assertions
    default clocking acc_cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    token_pass_a: assert property ($fell(chain_token_out) |->
        $past(st_ff.bus_st) == acc_pkg::ACC_OWN && $past(bit_strobe) && !$past(st_ff.rate_wr))
        else $error("token passed without finishing the owned bits");
    rate_write_a: assert property (bus_owner && st_ff.rate_wr |-> chain_token_out)
        else $error("token dropped during rate write");
    rate_read_a: assert property ($rose(st_ff.bus_st == acc_pkg::ACC_WAIT) &&
        $past(cmd_rate_read) |-> st_ff.bit_goal == 10'h010)
        else $error("rate read not sixteen bits per device");
    ovr_line_a: assert property (overrange_active |=> overrange_line_n_oe &&
        !overrange_line_n_o) else $error("overrange line not pulled low");
    fault_line_a: assert property (!fault_active |=> !fault_line_n_oe)
        else $error("fault line driven while no fault");
    ready_gate_a: assert property ($fell(ready_chain_out_n) |->
        !$past(st_ff.rdy_in_s[1]) && $past(st_ff.rdy_pending))
        else $error("ready fell without chain-in low and result");
    no_abort_a: assert property (sync_fall && converter_run &&
        st_ff.period_cnt < period_last |=> st_ff.period_cnt == $past(st_ff.period_cnt) + 17'h00001)
        else $error("sync disturbed running conversion");
    sync_meas_a: assert property (sync_fall && !rdy_fall |=>
        st_ff.stored == $past(st_ff.since_cnt) && st_ff.pend)
        else $error("sync interval not stored");
    zero_pause_a: assert property (sync_fall && rdy_fall |=> st_ff.stored == '0)
        else $error("same-cycle sync did not give zero pause");
    pause_load_a: assert property (rdy_fall && st_ff.pend |=>
        st_ff.pause_cnt == $past(st_ff.stored) ##1 (st_ff.period_cnt == $past(st_ff.period_cnt)
        || st_ff.pause_cnt == '0)) else $error("pause not loaded or converter ran");
    cs_release_a: assert property (st_ff.cs_s[1] |=> chain_token_out && !bus_owner)
        else $error("token not restored on chip select release");

    hand_over_c: cover property (bus_owner ##[1:64] $fell(chain_token_out));
    sync_pause_c: cover property (sync_fall ##[1:1000] !converter_run);
    buf_full_c: cover property (!conv_ready && conv_valid);
    rate_wr_c: cover property (bus_owner && st_ff.rate_wr ##[1:40] !bus_owner);
endmodule : acc_cascade
`default_nettype wire

// file: testbench/acc_far_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// upstream neighbour and pulled-up summary lines
module acc_far_model (
    input wire logic cs_n,
    input wire logic pass_en,
    input wire logic up_ready,
    input wire logic overrange_line_n_o,
    input wire logic overrange_line_n_oe,
    input wire logic fault_line_n_o,
    input wire logic fault_line_n_oe,
    output logic chain_token_in,
    output logic ready_chain_in_n,
    output logic ovr_wire_n,
    output logic flt_wire_n
);
    // token drops only inside a command, so it is high again for the next one
    assign chain_token_in = cs_n | ~pass_en;
    assign ready_chain_in_n = ~up_ready;
    // pull-up wins unless some device pulls low
    assign ovr_wire_n = overrange_line_n_oe ? overrange_line_n_o : 1'b1;
    assign flt_wire_n = fault_line_n_oe ? fault_line_n_o : 1'b1;
endmodule : acc_far_model
`default_nettype wire

// file: testbench/acc_cascade_test.sv
`timescale 1ns/1ns
`default_nettype none
module acc_cascade_test;
    // ==========================================
    // signals
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic cs_n = 1'b1;
    logic cmd_start = 1'b0;
    logic cmd_rate_write = 1'b0;
    logic cmd_rate_read = 1'b0;
    logic [acc_pkg::BIT_W-1:0] cmd_bits = 10'h002;
    logic bit_strobe = 1'b0;
    logic overrange_active = 1'b0;
    logic fault_active = 1'b0;
    logic sync_n = 1'b1;
    logic [acc_pkg::CNT_W-1:0] period_cycles = 17'h00014;
    logic conv_valid = 1'b0;
    logic [acc_pkg::DATA_W-1:0] conv_data = 24'h000000;
    logic out_ready = 1'b0;
    logic pass_en = 1'b0;
    logic up_ready = 1'b0;
    logic chain_token_in, ready_chain_in_n, ovr_wire_n, flt_wire_n, chain_token_out, bus_owner;
    logic overrange_line_n_o, overrange_line_n_oe, fault_line_n_o, fault_line_n_oe;
    logic ready_chain_out_n, conv_tick, converter_run, conv_ready, out_valid;
    logic [acc_pkg::DATA_W-1:0] out_data;
    int miscompares = 0;
    int compares = 0;
    int cyc = 0;
    int gap = 0;
    int run_lo = 0;
    int gaps[$];
    bit logging = 1'b0;

    acc_cascade acc_cascade_inst (
        .clk_sys, .arst_n, .cs_n, .chain_token_in, .chain_token_out, .cmd_start,
        .cmd_rate_write, .cmd_rate_read, .cmd_bits, .bit_strobe, .bus_owner,
        .overrange_active, .fault_active, .overrange_line_n_o, .overrange_line_n_oe,
        .fault_line_n_o, .fault_line_n_oe, .sync_n, .ready_chain_in_n,
        .ready_chain_out_n, .period_cycles, .conv_tick, .converter_run, .conv_valid,
        .conv_data, .conv_ready, .out_valid, .out_data, .out_ready
    );
    acc_far_model acc_far_model_inst (
        .cs_n, .pass_en, .up_ready, .overrange_line_n_o, .overrange_line_n_oe,
        .fault_line_n_o, .fault_line_n_oe, .chain_token_in, .ready_chain_in_n,
        .ovr_wire_n, .flt_wire_n
    );

    always #10 clk_sys = ~clk_sys;

    // ==========================================
    // monitor: sampled at the falling edge, clear of the design's updates
    always @(negedge clk_sys) begin
        cyc++;
        if (!converter_run) run_lo++;
        if (conv_tick && logging) gaps.push_back(gap + 1);
        gap = conv_tick ? 0 : gap + 1;
        // ceiling last, so nothing runs after the verdict
        if (cyc == 3000) begin
            miscompares++;
            print_verdict();
        end
    end

    // ==========================================
    // helpers
    task automatic print_verdict;
        if (miscompares == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic tk(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tk

    task automatic shift(input int n);
        bit_strobe = 1'b1;
        tk(n);
        bit_strobe = 1'b0;
    endtask : shift

    task automatic cmd(input logic wr, input logic rd);
        cs_n = 1'b0;
        tk(3);
        cmd_rate_write = wr;
        cmd_rate_read = rd;
        cmd_start = 1'b1;
        tk(1);
        cmd_start = 1'b0;
    endtask : cmd

    task automatic end_cmd;
        cs_n = 1'b1;
        pass_en = 1'b0;
        tk(4);
        check("token_release", chain_token_out, 1'b1);
    endtask : end_cmd

    // ==========================================
    // scenarios
    task automatic t_open_drain;
        overrange_active = 1'b1;
        tk(1);
        check("ovr_wire", ovr_wire_n, 1'b0);
        check("flt_wire", flt_wire_n, 1'b1);
        overrange_active = 1'b0;
        fault_active = 1'b1;
        tk(1);
        check("ovr_wire_idle", ovr_wire_n, 1'b1);
        check("flt_wire_low", flt_wire_n, 1'b0);
        fault_active = 1'b0;
    endtask : t_open_drain

    task automatic t_token;
        cmd(1'b0, 1'b0);
        tk(5);
        check("owner_early", bus_owner, 1'b0);
        pass_en = 1'b1;
        tk(4);
        shift(1);
        tk(1);
        check("owner_mid", bus_owner, 1'b1);
        shift(1);
        check("owner_done", bus_owner, 1'b0);
        check("token_pass", chain_token_out, 1'b0);
        end_cmd();
    endtask : t_token

    task automatic t_rate_write;
        cmd(1'b1, 1'b0);
        check("wr_owner", bus_owner, 1'b1);
        shift(15);
        tk(1);
        check("wr_owner_15", bus_owner, 1'b1);
        shift(1);
        check("wr_owner_16", bus_owner, 1'b0);
        check("wr_token", chain_token_out, 1'b1);
        end_cmd();
    endtask : t_rate_write

    task automatic t_rate_read;
        cmd(1'b0, 1'b1);
        pass_en = 1'b1;
        tk(4);
        shift(15);
        tk(1);
        check("rd_owner_15", bus_owner, 1'b1);
        shift(1);
        check("rd_owner_16", bus_owner, 1'b0);
        check("rd_token", chain_token_out, 1'b0);
        end_cmd();
    endtask : t_rate_read

    task automatic t_buffer;
        conv_data = 24'h00a5a5;
        conv_valid = 1'b1;
        tk(1);
        conv_data = 24'h005a5a;
        tk(1);
        conv_valid = 1'b0;
        check("buf_full", conv_ready, 1'b0);
        tk(4);
        check("ready_held", ready_chain_out_n, 1'b1);
        up_ready = 1'b1;
        tk(4);
        check("ready_low", ready_chain_out_n, 1'b0);
        check("head_data", out_data, 24'h00a5a5);
        out_ready = 1'b1;
        tk(1);
        check("tail_data", out_data, 24'h005a5a);
        tk(1);
        check("drained", out_valid, 1'b0);
        check("no_pause", run_lo, 0);
        tk(10);
    endtask : t_buffer

    task automatic t_sync;
        int good;
        good = 0;
        logging = 1'b1;
        conv_valid = 1'b1;
        tk(1);
        conv_valid = 1'b0;
        tk(1);
        check("ready_fall", ready_chain_out_n, 1'b0);
        tk(3);
        sync_n = 1'b0;
        tk(2);
        sync_n = 1'b1;
        tk(3);
        sync_n = 1'b0;
        tk(10);
        run_lo = 0;
        conv_valid = 1'b1;
        tk(1);
        conv_valid = 1'b0;
        tk(80);
        logging = 1'b0;
        check("pause_len", run_lo >= 10 && run_lo <= 12, 1'b1);
        foreach (gaps[i]) begin
            if (gaps[i] == 20 + run_lo) begin
                good++;
            end else begin
                check("gap", gaps[i], 20);
            end
        end
        check("shifted_gap", good, 1);
    endtask : t_sync

    // sync pin falls one edge before the result, so both edges meet on one clock
    task automatic t_zero_sync;
        sync_n = 1'b1;
        tk(4);
        sync_n = 1'b0;
        tk(1);
        conv_valid = 1'b1;
        tk(1);
        conv_valid = 1'b0;
        tk(12);
        run_lo = 0;
        conv_valid = 1'b1;
        tk(1);
        conv_valid = 1'b0;
        tk(30);
        check("zero_pause", run_lo, 0);
    endtask : t_zero_sync

    initial begin
        tk(2);
        sync_n = 1'b0;
        tk(2);
        sync_n = 1'b1;
        tk(2);
        arst_n = 1'b1;
        tk(3);
        t_open_drain();
        t_token();
        t_rate_write();
        t_rate_read();
        t_buffer();
        t_sync();
        t_zero_sync();
        print_verdict();
    end
endmodule : acc_cascade_test
`default_nettype wire
